// file: eeprom_params.svh
// Constants for the two-wire serial memory slave
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

// Device address word: fixed upper nibble
`define DEV_PREFIX 4'hA
// Bits in one transferred word
`define WORD_BITS 4'h8
// Memory size and page size in bytes
`define MEM_DEPTH 256
`define PAGE_BYTES 8
// Page buffer shape: word address plus data byte
`define PBUF_WIDTH 16
`define PBUF_DEPTH 16
// Clock period and longest internal write time
`define CLK_PERIOD_NS 50
`define WRITE_TIME_NS 5000000
// Longest time rounds down to whole cycles
`define WRITE_CYCLES (`WRITE_TIME_NS / `CLK_PERIOD_NS)

`endif

// file: eeprom_pkg.sv
// Types shared by the serial memory slave modules
package eeprom_pkg;

	// Link sequencer states
	typedef enum logic [2:0] {
		S_IDLE,
		S_DEV,
		S_WADDR,
		S_WDATA,
		S_READ
	} link_state_e;

	// One memory byte and one word address
	typedef logic [7:0] byte_t;
	typedef logic [7:0] addr_t;

endpackage

// file: pbuf_if.sv
// Handshake bundle between the link logic and the page buffer
`timescale 1ns/1ps
`default_nettype none
interface pbuf_if #(parameter int WIDTH = 16);
	// Filling side
	logic push_valid;
	logic push_ready;
	logic [WIDTH-1:0] push_data;
	// Draining side
	logic pop_valid;
	logic pop_ready;
	logic [WIDTH-1:0] pop_data;

	// Link logic: fills and drains
	modport user(output push_valid, output push_data, input push_ready,
		input pop_valid, input pop_data, output pop_ready);
	// Buffer itself
	modport store(input push_valid, input push_data, output push_ready,
		output pop_valid, output pop_data, input pop_ready);
endinterface
`default_nettype wire

// file: pbuf_fifo.sv
// Small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pbuf_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and synchronous reset
	input wire logic clk,
	input wire logic nrst,
	// Both handshake sides
	pbuf_if.store bus
);
	localparam int AW = $clog2(DEPTH);

	// Storage and pointers with a wrap bit
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic full;
	logic empty;

	// Full when pointers differ only in the wrap bit
	assign empty = (wr_ptr_r == rd_ptr_r);
	assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
		(wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign bus.push_ready = !full;
	assign bus.pop_valid = !empty;
	assign bus.pop_data = mem_r[rd_ptr_r[AW-1:0]];

	// Write side
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wr_ptr_r <= '0;
		end else if (bus.push_valid && !full) begin
			mem_r[wr_ptr_r[AW-1:0]] <= bus.push_data;
			wr_ptr_r <= wr_ptr_r + {{AW{1'b0}}, 1'b1};
		end
	end

	// Read side
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rd_ptr_r <= '0;
		end else if (bus.pop_ready && !empty) begin
			rd_ptr_r <= rd_ptr_r + {{AW{1'b0}}, 1'b1};
		end
	end
endmodule
`default_nettype wire

// file: eeprom_slave.sv
// Two-wire serial memory slave: link sequencer, array and write cycle
// Functional notes
// RQ1 - Data changes only while clock low
// RQ2 - Data falling, clock high: start
// RQ3 - Stop after read returns to standby
// RQ4 - Eight-bit words, ack low on ninth
// RQ5 - Standby at reset and after stop
// RQ6 - Master recovers with clocks then start
// RQ7 - Address word: 1010, straps, direction
// RQ8 - Direction bit one reads, zero writes
// RQ9 - Ack on match, else back to standby
// RQ10 - Byte write: address, word, data, stop
// RQ11 - Internal write ignores all inputs
// RQ12 - Write time starts at stop
// RQ13 - Page write up to eight bytes
// RQ14 - Only low three address bits advance
// RQ15 - Page overflow overwrites earlier bytes
// RQ16 - Polling acked only once write done
// RQ17 - Address counter holds last plus one
// RQ18 - Read address wraps whole array
// RQ19 - Current read: counter byte shifted out
// RQ20 - Random read uses dummy write first
// RQ21 - Master ack continues sequential read
// RQ22 - Master ends read with nack, stop
// RQ23 - 256 bytes, 32 pages of eight
// RQ24 - Write protect high blocks array writes
// RQ25 - Mismatch: release line, wait for start
`include "eeprom_params.svh"
`timescale 1ns/1ps
`default_nettype none
module eeprom_slave #(
	// Internal write time in clock cycles
	parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
	// Clock and synchronous active-low reset
	input wire logic CLK,
	input wire logic NRST,
	// Serial link
	input wire logic SCL,
	input wire logic SDA_IN,
	output var logic SDA_OUT,
	output var logic SDA_OE_N,
	// Strap and protect pins
	input wire logic STRAP_BIT_LOW,
	input wire logic STRAP_BIT_MID,
	input wire logic STRAP_BIT_HIGH,
	input wire logic WP,
	// Status
	output var logic STANDBY
);

	// Pin synchronisers: scl, sda, three straps, protect
	logic [5:0] pin_meta_r;
	logic [5:0] pin_sync_r;
	logic [1:0] line_prev_r;
	logic scl_now;
	logic sda_now;
	logic [2:0] strap_now;
	logic wp_now;

	// Line events on the clock domain
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	// Link sequencer state
	eeprom_pkg::link_state_e state_r;
	logic [3:0] bit_cnt_r;
	logic ack_phase_r;
	eeprom_pkg::byte_t shift_r;
	eeprom_pkg::byte_t tx_r;
	logic rw_r;
	logic pushed_r;
	logic sda_oe_n_r;
	eeprom_pkg::addr_t addr_cnt_r;

	// Page buffer filling side
	logic push_valid_r;
	logic [15:0] push_data_r;
	logic prog_go_r;

	// Internal write cycle
	logic busy_r;
	logic [31:0] wait_cnt_r;
	logic wait_done;

	// Output flops
	logic sda_out_r;
	logic standby_r;

	// Memory array
	eeprom_pkg::byte_t mem_r [`MEM_DEPTH];
	eeprom_pkg::byte_t rd_byte;
	logic dev_match;

	// Page buffer handshake bundle
	pbuf_if #(.WIDTH(`PBUF_WIDTH)) pbuf();

	// Buffer holds a page; depth above a page gives slack
	pbuf_fifo #(
		.WIDTH(`PBUF_WIDTH),
		.DEPTH(`PBUF_DEPTH)
	) u_pbuf (
		.clk(CLK),
		.nrst(NRST),
		.bus(pbuf.store)
	);

	// Two flops on every pin before any logic looks at it
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			pin_meta_r <= 6'h3F;
			pin_sync_r <= 6'h3F;
		end else begin
			pin_meta_r <= {WP, STRAP_BIT_HIGH, STRAP_BIT_MID,
				STRAP_BIT_LOW, SDA_IN, SCL};
			pin_sync_r <= pin_meta_r;
		end
	end

	// Previous synchronised line levels for edge finding
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			line_prev_r <= 2'h3;
		end else begin
			line_prev_r <= pin_sync_r[1:0];
		end
	end

	// Decoded line levels
	assign scl_now = pin_sync_r[0];
	assign sda_now = pin_sync_r[1];
	assign strap_now = pin_sync_r[4:2];
	assign wp_now = pin_sync_r[5];

	// Clock edges and data edges under clock high
	assign scl_rise = scl_now && !line_prev_r[0];
	assign scl_fall = !scl_now && line_prev_r[0];
	// Data moving with clock high marks start or stop [RQ1]
	assign start_det = scl_now && line_prev_r[0] &&
		!sda_now && line_prev_r[1]; // [RQ2]
	assign stop_det = scl_now && line_prev_r[0] &&
		sda_now && !line_prev_r[1];

	// Address word compare: fixed nibble then straps [RQ7]
	assign dev_match = (shift_r[7:4] == `DEV_PREFIX) &&
		(shift_r[3:1] == strap_now);
	// Byte at the address counter
	assign rd_byte = mem_r[addr_cnt_r];

	// Buffer connections
	assign pbuf.push_valid = push_valid_r;
	assign pbuf.push_data = push_data_r;
	// Drain only while the write cycle runs
	assign pbuf.pop_ready = busy_r;

	// Link sequencer: start, stop, clock rise and fall
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			state_r <= eeprom_pkg::S_IDLE;
			bit_cnt_r <= 4'h0;
			ack_phase_r <= 1'b0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			rw_r <= 1'b0;
			pushed_r <= 1'b0;
			sda_oe_n_r <= 1'b1;
			addr_cnt_r <= 8'h00;
			push_valid_r <= 1'b0;
			push_data_r <= 16'h0000;
			prog_go_r <= 1'b0;
		end else begin
			// Pulses last one cycle
			push_valid_r <= 1'b0;
			prog_go_r <= 1'b0;
			if (start_det) begin
				// Every command opens here, also repeated starts [RQ2]
				state_r <= eeprom_pkg::S_DEV;
				bit_cnt_r <= 4'h0;
				ack_phase_r <= 1'b0;
				sda_oe_n_r <= 1'b1;
			end else if (stop_det) begin
				// Stop after queued data launches the write [RQ12]
				if (state_r == eeprom_pkg::S_WDATA && pushed_r) begin
					prog_go_r <= 1'b1; // [RQ10]
				end
				// Any stop, read or write, ends in idle [RQ3]
				state_r <= eeprom_pkg::S_IDLE;
				ack_phase_r <= 1'b0;
				sda_oe_n_r <= 1'b1;
			end else if (scl_rise) begin
				if (state_r == eeprom_pkg::S_READ) begin
					if (bit_cnt_r != `WORD_BITS) begin
						// Master samples our bit here
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (!sda_now) begin
						// Master ack: fetch the next byte [RQ21]
						tx_r <= rd_byte;
						addr_cnt_r <= addr_cnt_r + 8'h01; // [RQ18]
						bit_cnt_r <= 4'h0;
					end else begin
						// Master nack: wait for its stop [RQ22]
						state_r <= eeprom_pkg::S_IDLE;
					end
				end else if (state_r != eeprom_pkg::S_IDLE &&
					!ack_phase_r && bit_cnt_r != `WORD_BITS) begin
					// Receive one bit, most significant first [RQ4]
					shift_r <= {shift_r[6:0], sda_now};
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end
			end else if (scl_fall) begin
				if (state_r == eeprom_pkg::S_READ) begin
					if (bit_cnt_r == `WORD_BITS) begin
						// Let go for the master's ack bit
						sda_oe_n_r <= 1'b1;
					end else begin
						// Open drain: a one is a released line
						sda_oe_n_r <= tx_r[7];
						tx_r <= {tx_r[6:0], 1'b0};
					end
				end else if (ack_phase_r) begin
					// Ninth clock over: release and move on
					sda_oe_n_r <= 1'b1;
					ack_phase_r <= 1'b0;
					bit_cnt_r <= 4'h0;
					unique case (state_r)
						eeprom_pkg::S_DEV: begin
							if (rw_r) begin
								// Read: first bit goes out now [RQ19]
								state_r <= eeprom_pkg::S_READ;
								sda_oe_n_r <= rd_byte[7];
								tx_r <= {rd_byte[6:0], 1'b0};
								// Counter keeps last plus one [RQ17]
								addr_cnt_r <= addr_cnt_r + 8'h01;
							end else begin
								state_r <= eeprom_pkg::S_WADDR;
							end
						end
						eeprom_pkg::S_WADDR: begin
							// Dummy write may stop here [RQ20]
							state_r <= eeprom_pkg::S_WDATA;
						end
						eeprom_pkg::S_WDATA: begin
							// More page bytes may follow [RQ13]
							state_r <= eeprom_pkg::S_WDATA;
						end
						eeprom_pkg::S_IDLE: begin
							state_r <= eeprom_pkg::S_IDLE;
						end
						eeprom_pkg::S_READ: begin
							state_r <= eeprom_pkg::S_READ;
						end
					endcase
				end else if (bit_cnt_r == `WORD_BITS &&
					state_r != eeprom_pkg::S_IDLE) begin
					// Eighth bit in: decide the ack [RQ4]
					unique case (state_r)
						eeprom_pkg::S_DEV: begin
							if (dev_match && !busy_r) begin
								// Ack low, polling sees it only when idle
								sda_oe_n_r <= 1'b0; // [RQ9] [RQ16]
								ack_phase_r <= 1'b1;
								rw_r <= shift_r[0]; // [RQ8]
								pushed_r <= 1'b0;
							end else begin
								// No match or busy: line stays released
								state_r <= eeprom_pkg::S_IDLE; // [RQ25] [RQ11]
							end
						end
						eeprom_pkg::S_WADDR: begin
							// Any of the 256 bytes selectable [RQ23]
							addr_cnt_r <= shift_r;
							sda_oe_n_r <= 1'b0; // [RQ10]
							ack_phase_r <= 1'b1;
						end
						eeprom_pkg::S_WDATA: begin
							if (pbuf.push_ready) begin
								sda_oe_n_r <= 1'b0; // [RQ13]
								ack_phase_r <= 1'b1;
								// Protected array: byte acked, dropped [RQ24]
								if (!wp_now) begin
									push_valid_r <= 1'b1;
									push_data_r <= {addr_cnt_r, shift_r};
									pushed_r <= 1'b1;
								end
								// Wrap inside the page [RQ14] [RQ15]
								addr_cnt_r <= {addr_cnt_r[7:3],
									addr_cnt_r[2:0] + 3'h1};
							end else begin
								// Buffer full: refuse with a nack
								state_r <= eeprom_pkg::S_IDLE;
							end
						end
						eeprom_pkg::S_IDLE: begin
							state_r <= eeprom_pkg::S_IDLE;
						end
						eeprom_pkg::S_READ: begin
							state_r <= eeprom_pkg::S_READ;
						end
					endcase
				end
			end
		end
	end

	// Write time elapsed
	assign wait_done = (wait_cnt_r == 32'(WRITE_CYCLES - 1));

	// Self-timed write cycle from stop to completion [RQ12]
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			busy_r <= 1'b0;
			wait_cnt_r <= 32'h0000_0000;
		end else if (prog_go_r) begin
			busy_r <= 1'b1;
			wait_cnt_r <= 32'h0000_0000;
		end else if (busy_r) begin
			// Finish only when the time is up and buffer drained
			if (wait_done && !pbuf.pop_valid) begin
				busy_r <= 1'b0;
			end else if (!wait_done) begin
				wait_cnt_r <= wait_cnt_r + 32'h0000_0001;
			end
		end
	end

	// Array update; later bytes to one address win [RQ15]
	always_ff @(posedge CLK) begin
		if (busy_r && pbuf.pop_valid) begin
			mem_r[pbuf.pop_data[15:8]] <= pbuf.pop_data[7:0];
		end
	end

	// Driven level is always low; the enable does the work
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			sda_out_r <= 1'b0;
		end else begin
			sda_out_r <= 1'b0;
		end
	end

	// Standby once idle with no write in flight [RQ5] [RQ3]
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			standby_r <= 1'b1;
		end else begin
			standby_r <= (state_r == eeprom_pkg::S_IDLE) && !busy_r &&
				!prog_go_r;
		end
	end

	// Outputs straight from flops
	assign SDA_OUT = sda_out_r;
	assign SDA_OE_N = sda_oe_n_r;
	assign STANDBY = standby_r;

endmodule
`default_nettype wire

// file: eeprom_slave_props.sv
// Checker for the ports of the two-wire serial memory slave
`timescale 1ns/1ps
`default_nettype none
module eeprom_slave_props #(
	parameter int WRITE_CYCLES = 40
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Link and status
	input wire logic SCL,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE_N,
	input wire logic STANDBY
);
	// Busy cycles with both lines resting high
	int idle_cnt_r;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	// Restarts on any bus activity, so polling never inflates it
	always_ff @(posedge CLK) begin
		if (!NRST || STANDBY || !(SCL && SDA_IN)) begin
			idle_cnt_r <= 0;
		end else begin
			idle_cnt_r <= idle_cnt_r + 1;
		end
	end
	// Whole high phase of the link clock
	sequence s_scl_high;
		SCL [*4];
	endsequence
	// A low bit stands long enough to be sampled
	sequence s_pull_held;
		!SDA_OE_N [*6];
	endsequence
	a_reset_release:
		assert property (disable iff (1'b0) !NRST |=> SDA_OE_N && STANDBY)
		else $error("pin driven or busy after reset");
	a_out_level:
		assert property (SDA_OUT == 1'b0)
		else $error("data pin driven high");
	a_oe_steady:
		assert property (s_scl_high |-> $stable(SDA_OE_N))
		else $error("data changed while link clock high");
	a_change_after_fall:
		assert property ($changed(SDA_OE_N) |-> !$past(SCL, 2))
		else $error("data changed near a link clock rise");
	a_pull_held:
		assert property ($fell(SDA_OE_N) |-> s_pull_held)
		else $error("low bit released too soon");
	a_quiet_standby:
		assert property (STANDBY |-> SDA_OE_N)
		else $error("pin driven in standby");
	a_start_wakes:
		assert property (SCL && $past(SCL) && $fell(SDA_IN) && STANDBY
			|-> ##[1:8] !STANDBY)
		else $error("start did not leave standby");
	a_write_bounded:
		assert property (idle_cnt_r < WRITE_CYCLES + 40)
		else $error("internal write ran too long");
endmodule
bind eeprom_slave eeprom_slave_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
	.CLK(CLK), .NRST(NRST), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
	.SDA_OE_N(SDA_OE_N), .STANDBY(STANDBY));
`default_nettype wire

// file: twi_master_model.sv
// Two-wire bus master model: link clock and open-drain data drive
`timescale 1ns/1ps
`default_nettype none
module twi_master_model (
	// Bench clock for pacing
	input wire logic clk,
	// Resolved data wire
	input wire logic sda,
	// Link clock and data drive, 1 = released
	output var logic scl,
	output var logic sda_rel
);
	// Lines idle high; the link clock stands still between frames
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	// All changes land on the bench clock's falling edge
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Start, also serving as repeated start
	task automatic start();
		tick(1);
		sda_rel = 1'b1;
		tick(3);
		scl = 1'b1;
		tick(4);
		sda_rel = 1'b0;
		tick(4);
		scl = 1'b0;
	endtask
	// Stop leaves both lines high
	task automatic stop();
		tick(1);
		sda_rel = 1'b0;
		tick(3);
		scl = 1'b1;
		tick(4);
		sda_rel = 1'b1;
		tick(4);
	endtask
	// One clock of 8 cycles: data set while low, sampled mid high
	task automatic bit_cycle(input logic b, output logic r);
		tick(1);
		sda_rel = b;
		tick(3);
		scl = 1'b1;
		tick(2);
		r = sda;
		tick(2);
		scl = 1'b0;
	endtask
	// Byte out MSB first, then the ninth clock for the answer
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(d[i], r);
		end
		bit_cycle(1'b1, r);
		ack = !r;
	endtask
	// Byte in; a low ninth bit asks for more, high ends the read
	task automatic get_byte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(1'b1, r);
			d[i] = r;
		end
		bit_cycle(!more, r);
	endtask
	// Recovery: clock until the line reads high, start in that high phase
	task automatic recover();
		logic seen;
		seen = 1'b0;
		sda_rel = 1'b1;
		for (int i = 0; i < 9 && !seen; i++) begin
			tick(4);
			scl = 1'b1;
			tick(2);
			seen = sda;
			if (!seen) begin
				// Slave still pulls: finish this clock
				tick(2);
				scl = 1'b0;
			end
		end
		// Clock still high: falling data is a start
		tick(2);
		sda_rel = 1'b0;
		tick(4);
		scl = 1'b0;
	endtask
endmodule
`default_nettype wire

// file: serial_eeprom_two_wire_slave_tb.sv
// Self-checking bench for the two-wire serial memory slave
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_two_wire_slave_tb;
	// Short write time keeps the run brief
	localparam int WC = 400;
	// Straps 101: write and read address words
	localparam logic [7:0] DEV_W = 8'hAA;
	localparam logic [7:0] DEV_R = 8'hAB;
	logic clk, nrst, wp, sda_out, sda_oe_n, standby, scl, sda_rel;
	int n_fail = 0;
	int check_count = 0;
	// Pull-up wire: low when either side pulls
	wire logic sda = sda_rel & (sda_oe_n | sda_out);
	eeprom_slave #(.WRITE_CYCLES(WC)) uut (.CLK(clk), .NRST(nrst),
		.SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
		.STRAP_BIT_LOW(1'b1), .STRAP_BIT_MID(1'b0), .STRAP_BIT_HIGH(1'b1),
		.WP(wp), .STANDBY(standby));
	twi_master_model m (.clk(clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
	// 50 ns clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Compare and count
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Byte out with the expected answer on the ninth clock
	task automatic send(input logic [7:0] w, input logic want);
		logic a;
		m.send_byte(w, a);
		check({7'h00, a}, {7'h00, want});
	endtask
	// Whole write frame ended by stop
	task automatic write_run(input logic [7:0] a, input logic [7:0] d[$]);
		m.start();
		send(DEV_W, 1'b1);
		send(a, 1'b1);
		foreach (d[i]) send(d[i], 1'b1);
		m.stop();
	endtask
	// Dummy write, repeated start, then sequential read
	task automatic read_run(input logic [7:0] a, input logic [7:0] e[$]);
		logic [7:0] b;
		m.start();
		send(DEV_W, 1'b1);
		send(a, 1'b1);
		m.start();
		send(DEV_R, 1'b1);
		foreach (e[i]) begin
			m.get_byte(i < e.size() - 1, b);
			check(b, e[i]);
		end
		m.stop();
	endtask
	// Wrong prefix or any wrong strap bit stays unanswered
	task automatic t_address();
		logic [7:0] bad[4] = '{8'h2A, 8'hA8, 8'hAE, 8'hA2};
		foreach (bad[i]) begin
			m.start();
			send(bad[i], 1'b0);
			m.stop();
		end
		m.start();
		send(DEV_W, 1'b1);
		m.stop();
		$display("test address done");
	endtask
	// Byte write, polling while busy and after, read back
	task automatic t_byte_write();
		write_run(8'h00, '{8'h5A});
		m.start();
		send(DEV_R, 1'b0);
		m.stop();
		check({7'h00, standby}, 8'h00);
		repeat (WC + 40) @(negedge clk);
		check({7'h00, standby}, 8'h01);
		m.start();
		send(DEV_W, 1'b1);
		m.stop();
		read_run(8'h00, '{8'h5A});
		$display("test byte write done");
	endtask
	// Ten bytes from 0x2E: wrap inside the page, overwrite the first two
	task automatic t_page_wrap();
		logic [7:0] d;
		write_run(8'h2E, '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85,
			8'h86, 8'h87, 8'h88, 8'h89});
		repeat (WC + 40) @(negedge clk);
		read_run(8'h28, '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
			8'h88});
		m.start();
		send(DEV_R, 1'b1);
		m.get_byte(1'b0, d);
		m.stop();
		check(d, 8'h89);
		check({7'h00, standby}, 8'h01);
		$display("test page wrap done");
	endtask
	// Write wraps in the top page; read wraps across the array end
	task automatic t_wrap_read();
		write_run(8'hFF, '{8'hA1, 8'hA2});
		repeat (WC + 40) @(negedge clk);
		read_run(8'hFF, '{8'hA1, 8'h5A});
		read_run(8'hF8, '{8'hA2});
		$display("test wrap read done");
	endtask
	// Read cut off mid-byte; recovery clocks, then a fresh command
	task automatic t_recover();
		logic r;
		logic [7:0] b;
		m.start();
		send(DEV_W, 1'b1);
		send(8'h28, 1'b1);
		m.start();
		send(DEV_R, 1'b1);
		m.bit_cycle(1'b1, r);
		check({7'h00, r}, 8'h01);
		m.recover();
		send(DEV_R, 1'b1);
		m.get_byte(1'b0, b);
		m.stop();
		check(b, 8'h83);
		$display("test recover done");
	endtask
	// Protected array: data acked, nothing stored, no busy time
	task automatic t_protect();
		wp = 1'b1;
		repeat (4) @(negedge clk);
		write_run(8'h00, '{8'hEE});
		m.start();
		send(DEV_W, 1'b1);
		m.stop();
		wp = 1'b0;
		read_run(8'h00, '{8'h5A});
		$display("test protect done");
	endtask
	// Main sequence
	initial begin
		nrst = 1'b0;
		wp = 1'b0;
		repeat (8) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		t_address();
		t_byte_write();
		t_page_wrap();
		t_wrap_read();
		t_recover();
		t_protect();
		wrap_up();
	end
	// Tests need about 6500 cycles; allow 20000
	initial begin
		#1000000;
		n_fail++;
		$display("unexpected at %0t: run hung", $time);
		wrap_up();
	end
endmodule
`default_nettype wire
